// File: verilog/dscg_pkg.sv
// Purpose: Constants for the deep-sleep clock gating register block.
// Assumes: One 32-bit register word per offset on a plain strobe port.
// Notes: Offsets below are byte addresses.
// Notes on behaviour
// - Enable one clocks unit; zero stops it.
// - Access to unclocked unit raises bus fault; only watchdog and converter fault here, retention has no fault path.
// - Run, sleep, deep-sleep each use own enables.
// - Sleep enables apply only with auto gating.
// - Reset loads 0x00000040, other enables cleared.
// - Bit 16 enables converter clock in deep-sleep.
// - Bits 9:8 select 125K, 250K, 500K rate.
// - Bit 6 enables retention module clock.
// - Bit 3 enables watchdog clock; unclocked access faults.
// - Reserved bits read zero, read-only.
package dscg_pkg;
    // ------------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------------
    localparam logic [11:0] DSCG_OFS_GATE = 12'h120;
    localparam logic [11:0] DSCG_OFS_CTRL = 12'h124;
    localparam logic [11:0] DSCG_OFS_STAT = 12'h128;
    localparam logic [11:0] DSCG_OFS_MASK = 12'h12C;
    // ------------------------------------------------------------------
    // Field layout and reset values.
    // ------------------------------------------------------------------
    localparam int DSCG_BIT_CONV = 16;
    localparam int DSCG_BIT_RET = 6;
    localparam int DSCG_BIT_WDOG = 3;
    localparam int DSCG_RATE_LO = 8;
    localparam logic [31:0] DSCG_WMASK = 32'h0001_0348;
    localparam logic [31:0] DSCG_GATE_RST = 32'h0000_0040;
    localparam logic [31:0] DSCG_CTRL_RST = 32'h0000_0000;
    localparam int DSCG_CTRL_AUTO = 0;
    localparam int DSCG_CTRL_W = 1;
    localparam int DSCG_STAT_W = 2;
    // Rate codes for the converter.
    localparam logic [1:0] DSCG_RATE_125K = 2'h0;
    localparam logic [1:0] DSCG_RATE_250K = 2'h1;
    localparam logic [1:0] DSCG_RATE_500K = 2'h2;
    // Power states.
    typedef enum logic [1:0]
    {
        DSCG_PS_RUN = 2'b00,
        DSCG_PS_SLEEP = 2'b01,
        DSCG_PS_DEEP = 2'b10
    } dscg_pstate_e;
endpackage : dscg_pkg

// File: verilog/dscg_top.sv
// Purpose: Deep-sleep clock gate register and per-unit enable selection.
// Assumes: Run and sleep gate registers live elsewhere and arrive as inputs.
// Notes: Status bit 0 is a watchdog fault, bit 1 a converter fault.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module dscg_top
(
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic [11:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic [1:0] PSTATE_I,
    input wire logic [31:0] RUN_GATE_I,
    input wire logic [31:0] SLEEP_GATE_I,
    input wire logic CONV_ACC_I,
    input wire logic WDOG_ACC_I,
    output logic CONV_CLK_EN_O,
    output logic RET_CLK_EN_O,
    output logic WDOG_CLK_EN_O,
    output logic [1:0] CONV_RATE_O,
    output logic [2:0] CONV_RATE_ONEHOT_O,
    output logic BUS_FAULT_O,
    output logic IRQ_O
);
    import dscg_pkg::*;

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    logic [31:0] gate;               // Deep-sleep gate register.
    logic [31:0] next_gate;
    logic [DSCG_CTRL_W-1:0] ctrl;    // Auto low-power gating select.
    logic [DSCG_CTRL_W-1:0] next_ctrl;
    logic [DSCG_STAT_W-1:0] stat;    // Sticky fault flags.
    logic [DSCG_STAT_W-1:0] next_stat;
    logic [DSCG_STAT_W-1:0] mask;    // Interrupt mask.
    logic [DSCG_STAT_W-1:0] next_mask;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic fault;
    logic next_fault;
    logic [31:0] eff;                // Enables in force this cycle.
    logic [DSCG_STAT_W-1:0] ev;      // Fault events this cycle.

    // ------------------------------------------------------------------
    // Enable selection per power state.
    // ------------------------------------------------------------------
    // Sleep tables only apply with auto gating; else run table holds.
    always_comb
    begin
        eff = RUN_GATE_I;
        if (ctrl[DSCG_CTRL_AUTO])
        begin
            if (PSTATE_I == DSCG_PS_SLEEP)
            begin
                eff = SLEEP_GATE_I;
            end
            else if (PSTATE_I == DSCG_PS_DEEP)
            begin
                eff = gate;
            end
        end
    end

    // Unit clocks follow the selected enables directly.
    assign CONV_CLK_EN_O = eff[DSCG_BIT_CONV];
    assign RET_CLK_EN_O = eff[DSCG_BIT_RET];
    assign WDOG_CLK_EN_O = eff[DSCG_BIT_WDOG];
    // The rate code is software's; 2'h3 is not checked by hardware.
    assign CONV_RATE_O = gate[DSCG_RATE_LO+1:DSCG_RATE_LO];
    always_comb
    begin
        CONV_RATE_ONEHOT_O = 3'h0;
        unique case (CONV_RATE_O)
            DSCG_RATE_125K: CONV_RATE_ONEHOT_O = 3'h1;
            DSCG_RATE_250K: CONV_RATE_ONEHOT_O = 3'h2;
            DSCG_RATE_500K: CONV_RATE_ONEHOT_O = 3'h4;
            default: CONV_RATE_ONEHOT_O = 3'h0;
        endcase
    end

    // ------------------------------------------------------------------
    // Fault detection.
    // ------------------------------------------------------------------
    // The retention module has no fault path, only the other two.
    assign ev[0] = WDOG_ACC_I & ~eff[DSCG_BIT_WDOG];
    assign ev[1] = CONV_ACC_I & ~eff[DSCG_BIT_CONV];

    // ------------------------------------------------------------------
    // Register next-state logic.
    // ------------------------------------------------------------------
    // Read of status clears it, but a new event wins over the clear.
    always_comb
    begin
        next_gate = gate;
        next_ctrl = ctrl;
        next_mask = mask;
        next_stat = stat;
        next_rdata = 32'h0000_0000;
        next_fault = |ev;
        if (WR_I)
        begin
            unique case (ADDR_I)
                DSCG_OFS_GATE: next_gate = WDATA_I & DSCG_WMASK;
                DSCG_OFS_CTRL: next_ctrl = WDATA_I[DSCG_CTRL_W-1:0];
                DSCG_OFS_MASK: next_mask = WDATA_I[DSCG_STAT_W-1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (RD_I)
        begin
            unique case (ADDR_I)
                DSCG_OFS_GATE: next_rdata = gate & DSCG_WMASK;
                DSCG_OFS_CTRL: next_rdata = {{(32-DSCG_CTRL_W){1'b0}}, ctrl};
                DSCG_OFS_STAT:
                begin
                    next_rdata = {{(32-DSCG_STAT_W){1'b0}}, stat};
                    next_stat = '0;
                end
                DSCG_OFS_MASK: next_rdata = {{(32-DSCG_STAT_W){1'b0}}, mask};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_stat = next_stat | ev;
    end

    // Register stage only.
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            gate <= DSCG_GATE_RST;
            ctrl <= DSCG_CTRL_RST[DSCG_CTRL_W-1:0];
            stat <= '0;
            mask <= '0;
            rdata <= 32'h0000_0000;
            fault <= 1'b0;
        end
        else
        begin
            gate <= next_gate;
            ctrl <= next_ctrl;
            stat <= next_stat;
            mask <= next_mask;
            rdata <= next_rdata;
            fault <= next_fault;
        end
    end

    assign RDATA_O = rdata;
    assign BUS_FAULT_O = fault;
    assign IRQ_O = |(stat & mask);

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    // Write-data fields held as plain nets, so that $past sees a signal.
    logic [1:0] wr_rate;             // Rate code on the write bus.
    logic wr_conv;                   // Converter enable on the write bus.
    logic wr_auto;                   // Auto gating select on the write bus.
    assign wr_rate = WDATA_I[DSCG_RATE_LO+1:DSCG_RATE_LO];
    assign wr_conv = WDATA_I[DSCG_BIT_CONV];
    assign wr_auto = WDATA_I[DSCG_CTRL_AUTO];

    // An access to an unclocked watchdog must fault in the next cycle.
    property p_wdog_fault;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (WDOG_ACC_I && !WDOG_CLK_EN_O) |=> BUS_FAULT_O && stat[0];
    endproperty
    a_wdog_fault: assert property (p_wdog_fault) else $error("watchdog fault missed");

    // An access to an unclocked converter must fault in the next cycle.
    property p_conv_fault;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (CONV_ACC_I && !CONV_CLK_EN_O) |=> BUS_FAULT_O && stat[1];
    endproperty
    a_conv_fault: assert property (p_conv_fault) else $error("converter fault missed");

    // A clocked unit must never produce a fault.
    property p_no_fault;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !((WDOG_ACC_I && !WDOG_CLK_EN_O) || (CONV_ACC_I && !CONV_CLK_EN_O)) |=> !BUS_FAULT_O;
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("spurious fault");

    // In deep-sleep with auto gating, this register drives the enables.
    property p_deep;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (ctrl[DSCG_CTRL_AUTO] && PSTATE_I == DSCG_PS_DEEP)
            |-> WDOG_CLK_EN_O == gate[DSCG_BIT_WDOG] && RET_CLK_EN_O == gate[DSCG_BIT_RET];
    endproperty
    a_deep: assert property (p_deep) else $error("deep enables wrong");

    // Without auto gating the run table holds in every power state.
    property p_noauto;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !ctrl[DSCG_CTRL_AUTO] |-> CONV_CLK_EN_O == RUN_GATE_I[DSCG_BIT_CONV];
    endproperty
    a_noauto: assert property (p_noauto) else $error("auto gating ignored");

    // Reserved positions never store a written one.
    property p_resv;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && ADDR_I == DSCG_OFS_GATE) |=> (gate & ~DSCG_WMASK) == 32'h0000_0000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit stored");

    // Gate readback shows the register with reserved bits at zero.
    property p_rd;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (RD_I && ADDR_I == DSCG_OFS_GATE)
            |=> RDATA_O == $past(gate) && RDATA_O[31:17] == 15'h0000;
    endproperty
    a_rd: assert property (p_rd) else $error("gate readback wrong");

    // The rate field follows the written code.
    property p_rate;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && ADDR_I == DSCG_OFS_GATE) |=> CONV_RATE_O == $past(wr_rate);
    endproperty
    a_rate: assert property (p_rate) else $error("rate field not stored");

    // The converter enable bit follows the written value.
    property p_conv_bit;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && ADDR_I == DSCG_OFS_GATE) |=> gate[DSCG_BIT_CONV] == $past(wr_conv);
    endproperty
    a_conv_bit: assert property (p_conv_bit) else $error("converter bit not stored");

    // Leaving reset the register holds its documented value.
    property p_reset;
        @(posedge MCLK_I) $rose(RESETN_I) |-> gate == DSCG_GATE_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset value");

    // In deep-sleep with auto gating, bit 16 clocks the converter.
    property p_deep_conv;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (ctrl[DSCG_CTRL_AUTO] && PSTATE_I == DSCG_PS_DEEP)
            |-> CONV_CLK_EN_O == gate[DSCG_BIT_CONV];
    endproperty
    a_deep_conv: assert property (p_deep_conv) else $error("deep converter enable wrong");

    // In sleep with auto gating, the sleep table drives the enables.
    property p_sleep;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (ctrl[DSCG_CTRL_AUTO] && PSTATE_I == DSCG_PS_SLEEP)
            |-> CONV_CLK_EN_O == SLEEP_GATE_I[DSCG_BIT_CONV]
            && WDOG_CLK_EN_O == SLEEP_GATE_I[DSCG_BIT_WDOG];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep enables wrong");

    // The retention module follows the run table without auto gating.
    property p_ret_run;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !ctrl[DSCG_CTRL_AUTO] |-> RET_CLK_EN_O == RUN_GATE_I[DSCG_BIT_RET];
    endproperty
    a_ret_run: assert property (p_ret_run) else $error("retention enable wrong");

    // Without a gate write the register keeps its value.
    property p_gate_hold;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !(WR_I && ADDR_I == DSCG_OFS_GATE) |=> $stable(gate);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate changed unwritten");

    // A status read returns the flags as they stood at the strobe.
    property p_rd_stat;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (RD_I && ADDR_I == DSCG_OFS_STAT)
            |=> RDATA_O == {{(32-DSCG_STAT_W){1'b0}}, $past(stat)};
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("status readback wrong");

    // A status read with no new event leaves the flags clear.
    property p_stat_clear;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (RD_I && ADDR_I == DSCG_OFS_STAT && !WDOG_ACC_I && !CONV_ACC_I) |=> stat == '0;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

    // A fault flag stays set until software reads the status.
    property p_stat_sticky;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (stat[0] && !(RD_I && ADDR_I == DSCG_OFS_STAT)) |=> stat[0];
    endproperty
    a_stat_sticky: assert property (p_stat_sticky) else $error("watchdog flag lost");

    // Read data are zero outside the cycle after a read strobe.
    property p_rd_idle;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        !RD_I |=> RDATA_O == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

    // Every legal rate code lights exactly one rate line.
    property p_onehot;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (CONV_RATE_O != 2'h3) |-> $onehot(CONV_RATE_ONEHOT_O);
    endproperty
    a_onehot: assert property (p_onehot) else $error("rate decode wrong");

    // The auto gating select follows a control write.
    property p_ctrl_wr;
        @(posedge MCLK_I) disable iff (!RESETN_I)
        (WR_I && ADDR_I == DSCG_OFS_CTRL) |=> ctrl[DSCG_CTRL_AUTO] == $past(wr_auto);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("auto select not stored");
endmodule : dscg_top

// File: testbench/dscg_top_tb.sv
// Purpose: Self-checking bench for the deep-sleep clock gate register block.
// Assumes: Strobes are one cycle long and read data stand one cycle after the read strobe.
// Notes: Faults are provoked with the run table selected, so gate writes cannot hide them.
`timescale 1ns/1ps
module dscg_top_tb;
    import dscg_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus signals and counters.
    // ------------------------------------------------------------------
    logic mclk = 1'b0; // System clock, 8 ns period.
    logic resetn = 1'b0; // Active-low reset.
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic [1:0] pstate = 2'h0;
    logic [31:0] run_gate = 32'h0000_0000;
    logic [31:0] sleep_gate = 32'h0000_0000;
    logic conv_acc = 1'b0;
    logic wdog_acc = 1'b0;
    logic conv_en, ret_en, wdog_en, fault, irq;
    logic [1:0] rate;
    logic [2:0] onehot;
    int error_cnt = 0;
    int num_checks = 0;
    always #4 mclk = ~mclk;
    dscg_top dscg_top_i (.MCLK_I(mclk), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .PSTATE_I(pstate), .RUN_GATE_I(run_gate),
        .SLEEP_GATE_I(sleep_gate), .CONV_ACC_I(conv_acc), .WDOG_ACC_I(wdog_acc),
        .CONV_CLK_EN_O(conv_en), .RET_CLK_EN_O(ret_en), .WDOG_CLK_EN_O(wdog_en),
        .CONV_RATE_O(rate), .CONV_RATE_ONEHOT_O(onehot), .BUS_FAULT_O(fault), .IRQ_O(irq));
    // ------------------------------------------------------------------
    // Shared bus and comparison tasks.
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask : rd
    // A one-cycle access pulse; the fault flag must show in the next cycle only.
    task automatic poke(input logic w, input logic c, input logic e);
        @(posedge mclk);
        wdog_acc <= w;
        conv_acc <= c;
        @(posedge mclk);
        wdog_acc <= 1'b0;
        conv_acc <= 1'b0;
        #1;
        chk("fault", {31'h0, e}, {31'h0, fault});
    endtask : poke
    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_fields;
        rd(DSCG_OFS_GATE, 32'h0000_0040, "gate reset");
        wr(DSCG_OFS_GATE, 32'hFFFF_FEFF);
        rd(DSCG_OFS_GATE, 32'h0001_0248, "gate reserved");
        chk("onehot max", 32'h4, {29'h0, onehot});
        wr(DSCG_OFS_GATE, 32'h0000_0000);
        rd(DSCG_OFS_GATE, 32'h0000_0000, "gate clear");
        for (int i = 0; i < 3; i++)
        begin
            wr(DSCG_OFS_GATE, 32'(i) << 8);
            chk("rate", 32'(i), {30'h0, rate});
            chk("onehot", 32'h1 << i, {29'h0, onehot});
        end
        rd(12'h200, 32'h0000_0000, "unmapped");
    endtask : t_fields
    // Each power state must pick its own table; expected order is conv, ret, wdog.
    task automatic t_states;
        logic [2:0] exp [4];
        exp = '{3'b010, 3'b100, 3'b101, 3'b010};
        @(posedge mclk);
        run_gate <= 32'h0000_0040;
        sleep_gate <= 32'h0001_0000;
        wr(DSCG_OFS_CTRL, 32'h1);
        wr(DSCG_OFS_GATE, 32'h0001_0008);
        for (int s = 0; s < 4; s++)
        begin
            @(posedge mclk);
            pstate <= 2'(s);
            #1;
            chk("enables", {29'h0, exp[s]}, {29'h0, conv_en, ret_en, wdog_en});
        end
        @(posedge mclk);
        pstate <= 2'h2;
        wr(DSCG_OFS_CTRL, 32'h0);
        chk("no auto", 32'h2, {29'h0, conv_en, ret_en, wdog_en});
    endtask : t_states
    // Faults on unclocked units, status, mask and read-clear.
    task automatic t_fault;
        @(posedge mclk);
        pstate <= 2'h0;
        wr(DSCG_OFS_MASK, 32'h1);
        poke(1'b1, 1'b0, 1'b1);
        chk("irq set", 32'h1, {31'h0, irq});
        @(posedge mclk);
        #1;
        chk("fault pulse", 32'h0, {31'h0, fault});
        rd(DSCG_OFS_STAT, 32'h1, "stat wdog");
        chk("irq clear", 32'h0, {31'h0, irq});
        poke(1'b0, 1'b1, 1'b1);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(DSCG_OFS_STAT, 32'h2, "stat conv");
        @(posedge mclk);
        run_gate <= 32'h0001_0008;
        poke(1'b1, 1'b1, 1'b0);
        rd(DSCG_OFS_STAT, 32'h0, "stat none");
    endtask : t_fault
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------------
    // Main sequence and hang guard.
    // ------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        t_fields();
        t_states();
        t_fault();
        complete_run();
    end
    // The run is short; this guard only fires if a task never returns.
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        complete_run();
    end
endmodule : dscg_top_tb
